// *** core/dhip_pkg.sv ***
// Shared constants and types for the display host interface pins
package dhip_pkg;
    localparam int DB_W         = 18;       // Parallel data bus width
    localparam int SER_W        = 8;        // Serial byte width
    localparam int FRM_W        = 9;        // Serial frame incl. dc bit
    localparam int SYS_CLK_MHZ  = 250;      // System clock rate
    localparam int LINK_HALF_NS = 32;       // Half period of host made link clock
    localparam int LINK_HALF_CYC = (LINK_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int TMR_W        = 4;        // Phase timer width
    localparam int BEAT_W       = 5;        // Beat counter width
    localparam logic [TMR_W-1:0]  HALF_CNT   = TMR_W'(LINK_HALF_CYC - 1);
    localparam logic [BEAT_W-1:0] BEATS_MCU  = 5'h01;  // One strobe
    localparam logic [BEAT_W-1:0] BEATS_SER3 = 5'h09;  // dc + 8 data
    localparam logic [BEAT_W-1:0] BEATS_SER4 = 5'h08;  // 8 data, dc on wr pin
    localparam logic [BEAT_W-1:0] BEATS_SER2 = 5'h05;  // dc + 4 double beats
    localparam logic [BEAT_W-1:0] BEATS_RD   = 5'h08;  // Serial read beats
    localparam logic [3:0]        TXCNT_END  = 4'h8;   // Serial read bits sent
    localparam logic [BEAT_W-1:0] BEAT_ONE   = 5'h01;
    localparam logic [3:0]        CNT_ONE    = 4'h1;
    localparam logic [3:0]        CNT_ZERO   = 4'h0;
    // Pin vector positions after synchronising in the device
    localparam int P_CS  = 0;
    localparam int P_DC  = 1;
    localparam int P_WR  = 2;
    localparam int P_RD  = 3;
    localparam int P_SDA = 4;
    localparam int P_STR = 5;
    localparam int P_PCK = 6;
    localparam int P_DE  = 7;
    localparam int P_HS  = 8;
    localparam int P_VS  = 9;
    localparam int P_W   = 10;
    typedef enum logic [2:0] {
        DHIP_MCU, DHIP_SER3, DHIP_SER4, DHIP_SER2, DHIP_RGB
    } dhip_mode_t;
endpackage

// *** core/dhip_if.sv ***
// Pin level carrier joining the host end and the display end
`timescale 1ns/100ps
interface dhip_if;
    import dhip_pkg::*;
    logic              cs_b;                   // Chip select, low active
    logic              data_command_select;    // dc select / serial clock
    logic              wr_b;                   // Write strobe / 4-wire dc / 2nd data
    logic              rd_b;                   // Read strobe
    logic              interface_select_strap; // Low: bidir serial data pin
    logic              pclk;                   // Dot clock
    logic              pixel_data_enable;      // Pixel data enable
    logic              hsync;                  // Line sync
    logic              vsync;                  // Frame sync
    logic              h_sda_o;                // Host serial data drive
    logic              h_sda_oe;
    logic              d_sda_o;                // Device serial data drive
    logic              d_sda_oe;
    logic              d_sdo;                  // Device separate read output
    logic [DB_W-1:0]   h_db_o;                 // Host bus drive
    logic              h_db_oe;
    logic [DB_W-1:0]   d_db_o;                 // Device bus drive
    logic              d_db_oe;
    logic              sda;                    // Resolved serial data wire
    logic [DB_W-1:0]   parallel_data_bus;      // Resolved parallel bus wire
    // Wire levels, pull-up on serial data, bus held low when floating
    assign sda = d_sda_oe ? d_sda_o : (h_sda_oe ? h_sda_o : 1'b1);
    assign parallel_data_bus = d_db_oe ? d_db_o : (h_db_oe ? h_db_o : '0);
    modport dev (
        input  cs_b, data_command_select, wr_b, rd_b, interface_select_strap,
        input  pclk, pixel_data_enable, hsync, vsync, sda, parallel_data_bus,
        output d_sda_o, d_sda_oe, d_sdo, d_db_o, d_db_oe
    );
    modport host (
        output cs_b, data_command_select, wr_b, rd_b, interface_select_strap,
        output pclk, pixel_data_enable, hsync, vsync,
        output h_sda_o, h_sda_oe, h_db_o, h_db_oe,
        input  sda, d_sdo, parallel_data_bus
    );
endinterface

// *** core/dhip_dev.sv ***
// Display end of the host interface: MCU, serial and RGB receive paths
// Function
// R01: Serial data sampled on serial clock rise
// R02: Strap low bidir data pin, high input-only
// R03: Shared 18-bit bidirectional parallel bus
// R04: Parallel read data taken at strobe rise
// R05: Host sets dc high data, low command
// R06: dc select pin is serial clock
// R07: Write strobe is 4-wire serial dc
// R08: Write strobe is second two-line data
// R09: Host supplies dot clock, enable, syncs
// R10: RGB word taken per dot clock while enabled
`timescale 1ns/100ps
module dhip_dev
    import dhip_pkg::*;
(
    input  wire logic            i_sys_clk,     // System clock
    input  wire logic            i_rst_b,       // Async reset, low active
    dhip_if.dev                  link,          // Pins toward the host
    input  wire dhip_mode_t      i_mode,        // Selected interface
    input  wire logic [DB_W-1:0] i_rd_data,     // Data returned on reads
    input  wire logic            i_ser_rd_en,   // Answer serial commands
    output logic                 o_wr_valid,    // Received word pulse
    output logic                 o_wr_is_data,  // Word is display data
    output logic [DB_W-1:0]      o_wr_data,     // Received word
    output logic                 o_pix_valid,   // Pixel pulse
    output logic [DB_W-1:0]      o_pix_data,    // Pixel word
    output logic                 o_pix_hsync,   // Synchronised line sync
    output logic                 o_pix_vsync,   // Synchronised frame sync
    output logic                 o_strap        // Synchronised strap
);
    // Synchroniser stages and edge history
    logic [P_W-1:0]   p1_q, p2_q, pp_q;        // Control pins
    logic [DB_W-1:0]  b1_q, b2_q;              // Parallel bus
    logic [P_W-1:0]   pin_raw;
    // Serial receive and transmit state
    logic [3:0]       cnt_q, cnt_d;            // Beat counter
    logic [FRM_W-1:0] sh_q, sh_d;              // Receive shift register
    logic [SER_W-1:0] tx_q, tx_d;              // Transmit shift register
    logic [3:0]       txc_q, txc_d;            // Bits sent
    logic             txon_q, txon_d;          // Read answer active
    logic             so_q, so_d;              // Serial out bit
    // Parallel drive
    logic             dboe_q, dboe_d;
    logic [DB_W-1:0]  dbo_q, dbo_d;
    // Output registers
    logic             wv_q, wv_d, wdc_q, wdc_d, pv_q, pv_d;
    logic [DB_W-1:0]  wd_q, wd_d, pd_q, pd_d;
    // Edge and frame helpers
    logic             cs_on, sck_r, sck_f, wr_r, rd_f, rd_r, pck_r;
    logic [3:0]       last;                    // Last beat index of frame
    logic             done, dcbit;

    assign pin_raw = {link.vsync, link.hsync, link.pixel_data_enable, link.pclk,
                      link.interface_select_strap, link.sda, link.rd_b, link.wr_b,
                      link.data_command_select, link.cs_b};

    // Two-stage synchroniser, stage two and its one-cycle history feed logic
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            p1_q <= '1;
            p2_q <= '1;
            pp_q <= '1;
            b1_q <= '0;
            b2_q <= '0;
        end else begin
            p1_q <= pin_raw;
            p2_q <= p1_q;
            pp_q <= p2_q;
            b1_q <= link.parallel_data_bus;
            b2_q <= b1_q;
        end
    end

    // Edge detection on synchronised pins
    always_comb begin
        cs_on = ~p2_q[P_CS];
        sck_r = p2_q[P_DC] & ~pp_q[P_DC];       // R06
        sck_f = ~p2_q[P_DC] & pp_q[P_DC];
        wr_r  = p2_q[P_WR] & ~pp_q[P_WR];
        rd_f  = ~p2_q[P_RD] & pp_q[P_RD];
        rd_r  = p2_q[P_RD] & ~pp_q[P_RD];
        pck_r = p2_q[P_PCK] & ~pp_q[P_PCK];
    end

    // Frame length per serial mode
    always_comb begin
        case (i_mode)
            DHIP_SER4: last = 4'(BEATS_SER4 - BEAT_ONE);
            DHIP_SER2: last = 4'(BEATS_SER2 - BEAT_ONE);
            default:   last = 4'(BEATS_SER3 - BEAT_ONE);
        endcase
    end

    // Next state for all receive and answer paths
    always_comb begin
        cnt_d  = cnt_q;
        sh_d   = sh_q;
        tx_d   = tx_q;
        txc_d  = txc_q;
        txon_d = txon_q;
        so_d   = so_q;
        dboe_d = dboe_q;
        dbo_d  = dbo_q;
        wv_d   = 1'b0;
        wdc_d  = wdc_q;
        wd_d   = wd_q;
        pv_d   = 1'b0;
        pd_d   = pd_q;
        done   = 1'b0;
        dcbit  = 1'b0;
        case (i_mode)
            DHIP_MCU: begin
                // Write taken on strobe rise with dc level
                if (cs_on && wr_r) begin
                    wv_d  = 1'b1;
                    wd_d  = b2_q;                    // R03
                    wdc_d = p2_q[P_DC];              // R05
                end
                // Drive bus from strobe fall until its rise
                if (cs_on && rd_f) begin
                    dboe_d = 1'b1;                   // R03
                    dbo_d  = i_rd_data;
                end
                if (rd_r || !cs_on) begin
                    dboe_d = 1'b0;                   // R04
                end
            end
            DHIP_SER3, DHIP_SER4, DHIP_SER2: begin
                dboe_d = 1'b0;
                if (!cs_on) begin
                    // Deselect aborts frame and answer
                    cnt_d  = CNT_ZERO;
                    txon_d = 1'b0;
                end else if (txon_q) begin
                    // Answer bits change on clock fall
                    if (sck_f && txc_q != TXCNT_END) begin
                        so_d  = tx_q[SER_W-1];
                        tx_d  = {tx_q[SER_W-2:0], 1'b0};
                        txc_d = txc_q + CNT_ONE;
                    end else if (sck_r && txc_q == TXCNT_END) begin
                        txon_d = 1'b0;
                    end
                end else if (sck_r) begin
                    // Sample data on clock rise
                    if (i_mode == DHIP_SER2 && cnt_q != CNT_ZERO) begin
                        sh_d = {sh_q[FRM_W-3:0], p2_q[P_SDA], p2_q[P_WR]}; // R08
                    end else begin
                        sh_d = {sh_q[FRM_W-2:0], p2_q[P_SDA]};            // R01
                    end
                    cnt_d = cnt_q + CNT_ONE;
                    if (cnt_q == last) begin
                        done  = 1'b1;
                        cnt_d = CNT_ZERO;
                    end
                end
                if (done) begin
                    // 4-wire takes dc from write pin, others from first bit
                    dcbit = (i_mode == DHIP_SER4) ? p2_q[P_WR] : sh_d[FRM_W-1]; // R07
                    wv_d  = 1'b1;
                    wdc_d = dcbit;                   // R05
                    wd_d  = {{(DB_W-SER_W){1'b0}}, sh_d[SER_W-1:0]};
                    if (!dcbit && i_ser_rd_en) begin
                        txon_d = 1'b1;
                        tx_d   = i_rd_data[SER_W-1:0];
                        txc_d  = CNT_ZERO;
                    end
                end
            end
            DHIP_RGB: begin
                dboe_d = 1'b0;
                // Pixel taken on dot clock rise while enabled
                if (pck_r && p2_q[P_DE]) begin
                    pv_d = 1'b1;                     // R10
                    pd_d = b2_q;                     // R03
                end
            end
            default: begin
                dboe_d = 1'b0;
                txon_d = 1'b0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q  <= CNT_ZERO;
            sh_q   <= '0;
            tx_q   <= '0;
            txc_q  <= CNT_ZERO;
            txon_q <= 1'b0;
            so_q   <= 1'b0;
            dboe_q <= 1'b0;
            dbo_q  <= '0;
            wv_q   <= 1'b0;
            wdc_q  <= 1'b0;
            wd_q   <= '0;
            pv_q   <= 1'b0;
            pd_q   <= '0;
        end else begin
            cnt_q  <= cnt_d;
            sh_q   <= sh_d;
            tx_q   <= tx_d;
            txc_q  <= txc_d;
            txon_q <= txon_d;
            so_q   <= so_d;
            dboe_q <= dboe_d;
            dbo_q  <= dbo_d;
            wv_q   <= wv_d;
            wdc_q  <= wdc_d;
            wd_q   <= wd_d;
            pv_q   <= pv_d;
            pd_q   <= pd_d;
        end
    end

    // Pin drives: serial answer on data pin only while strap low
    assign link.d_sda_o  = so_q;
    assign link.d_sda_oe = txon_q & ~p2_q[P_STR];    // R02
    assign link.d_sdo    = so_q;
    assign link.d_db_o   = dbo_q;
    assign link.d_db_oe  = dboe_q;

    // User side outputs
    assign o_wr_valid   = wv_q;
    assign o_wr_is_data = wdc_q;
    assign o_wr_data    = wd_q;
    assign o_pix_valid  = pv_q;
    assign o_pix_data   = pd_q;
    assign o_pix_hsync  = p2_q[P_HS];
    assign o_pix_vsync  = p2_q[P_VS];
    assign o_strap      = p2_q[P_STR];
endmodule

// *** core/dhip_host.sv ***
// Host end: drives MCU, serial and RGB transfers toward the display
`timescale 1ns/100ps
module dhip_host
    import dhip_pkg::*;
(
    input  wire logic            i_sys_clk,    // System clock
    input  wire logic            i_rst_b,      // Async reset, low active
    dhip_if.host                 link,         // Pins toward the display
    input  wire dhip_mode_t      i_mode,       // Selected interface
    input  wire logic            i_strap,      // Strap level to drive
    input  wire logic            i_req_valid,  // Transfer request
    input  wire logic            i_req_read,   // Request is a read
    input  wire logic            i_req_dc,     // 1 data, 0 command
    input  wire logic [DB_W-1:0] i_req_data,   // Write data or pixel
    input  wire logic            i_req_hsync,  // Line sync with pixel
    input  wire logic            i_req_vsync,  // Frame sync with pixel
    output logic                 o_req_ready,  // Idle, request taken
    output logic                 o_rsp_valid,  // Read answer pulse
    output logic [DB_W-1:0]      o_rsp_data    // Read answer
);
    typedef enum {H_IDLE, H_LOW, H_HIGH} dhip_hst_t;
    dhip_hst_t         st_q, st_d;
    logic [TMR_W-1:0]  tm_q, tm_d;            // Phase timer
    logic [BEAT_W-1:0] bt_q, bt_d;            // Beat index
    logic [BEAT_W-1:0] nb_q, nb_d;            // Total beats
    logic [BEAT_W-1:0] tb_q, tb_d;            // Transmit beats
    logic [FRM_W-1:0]  sh_q, sh_d;            // Serial out frame
    logic [SER_W-1:0]  rx_q, rx_d;            // Serial in bits
    logic              rd_q, rd_d, hs_q, hs_d, vs_q, vs_d;
    dhip_mode_t        md_q, md_d;
    // Registered pin drives
    logic              cs_q, cs_d, sck_q, sck_d, wr_q, wr_d, rdb_q, rdb_d;
    logic              pck_q, pck_d, de_q, de_d, so_q, so_d, soe_q, soe_d;
    logic [DB_W-1:0]   dbo_q, dbo_d, rsp_q, rsp_d;
    logic              dboe_q, dboe_d, rv_q, rv_d;
    // Return path synchroniser
    logic [DB_W+1:0]   r1_q, r2_q;
    logic              ser_in;

    // Two-stage synchroniser on inputs from the display
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            r1_q <= '0;
            r2_q <= '0;
        end else begin
            r1_q <= {link.d_sdo, link.sda, link.parallel_data_bus};
            r2_q <= r1_q;
        end
    end
    // Strap high moves read data to the separate output
    assign ser_in = i_strap ? r2_q[DB_W+1] : r2_q[DB_W];   // R02

    // Transfer sequencer: each beat is a low then a high phase
    always_comb begin
        st_d = st_q;
        md_d = md_q;
        {tm_d, bt_d, nb_d, tb_d, sh_d, rx_d} = {tm_q, bt_q, nb_q, tb_q, sh_q, rx_q};
        {rd_d, hs_d, vs_d} = {rd_q, hs_q, vs_q};
        {cs_d, sck_d, wr_d, rdb_d, pck_d, de_d} = {cs_q, sck_q, wr_q, rdb_q, pck_q, de_q};
        {so_d, soe_d, dbo_d, dboe_d, rsp_d} = {so_q, soe_q, dbo_q, dboe_q, rsp_q};
        rv_d        = 1'b0;
        o_req_ready = (st_q == H_IDLE);
        case (st_q)
            H_IDLE: begin
                if (i_req_valid) begin
                    md_d = i_mode;
                    {rd_d, hs_d, vs_d} = {i_req_read, i_req_hsync, i_req_vsync};
                    sh_d = (i_mode == DHIP_SER4) ? {i_req_data[SER_W-1:0], 1'b0}
                                                 : {i_req_dc, i_req_data[SER_W-1:0]};
                    case (i_mode)
                        DHIP_SER3: tb_d = BEATS_SER3;
                        DHIP_SER4: tb_d = BEATS_SER4;
                        DHIP_SER2: tb_d = BEATS_SER2;
                        default:   tb_d = BEATS_MCU;
                    endcase
                    nb_d = ((i_mode == DHIP_SER3 || i_mode == DHIP_SER4 || i_mode == DHIP_SER2)
                            && i_req_read) ? tb_d + BEATS_RD : tb_d;
                    bt_d = '0;
                    cs_d = (i_mode == DHIP_RGB);
                    st_d = H_LOW;
                    tm_d = HALF_CNT;
                    // First low phase set-up
                    case (i_mode)
                        DHIP_MCU: begin
                            sck_d  = i_req_dc;                   // R05
                            wr_d   = i_req_read;
                            rdb_d  = ~i_req_read;
                            dboe_d = ~i_req_read;                // R03
                            dbo_d  = i_req_data;
                        end
                        DHIP_RGB: begin
                            pck_d  = 1'b0;                       // R09
                            de_d   = 1'b1;
                            dboe_d = 1'b1;
                            dbo_d  = i_req_data;
                        end
                        default: begin
                            sck_d = 1'b0;                        // R06
                            soe_d = 1'b1;
                            so_d  = sh_d[FRM_W-1];
                            wr_d  = (i_mode == DHIP_SER4) ? i_req_dc : 1'b1;   // R07
                            sh_d  = {sh_d[FRM_W-2:0], 1'b0};
                        end
                    endcase
                end
            end
            H_LOW: begin
                tm_d = tm_q - 1'b1;
                if (tm_q == '0) begin
                    tm_d = HALF_CNT;
                    st_d = H_HIGH;
                    // Rising phase: read data captured at strobe rise
                    if (md_q == DHIP_MCU && rd_q) begin
                        rsp_d = r2_q[DB_W-1:0];                  // R04
                    end
                    if (md_q != DHIP_MCU && md_q != DHIP_RGB && bt_q >= tb_q) begin
                        rx_d = {rx_q[SER_W-2:0], ser_in};
                    end
                    {wr_d, rdb_d} = (md_q == DHIP_MCU) ? 2'b11 : {wr_q, rdb_q};
                    sck_d = (md_q == DHIP_MCU) ? sck_q : 1'b1;
                    pck_d = 1'b1;
                    hs_d  = hs_q;
                end
            end
            H_HIGH: begin
                tm_d = tm_q - 1'b1;
                if (tm_q == '0) begin
                    tm_d = HALF_CNT;
                    bt_d = bt_q + BEAT_ONE;
                    if (bt_d == nb_q) begin
                        // Frame end: cs, dc/clock, strobes and pixel enable high, drivers off
                        st_d   = H_IDLE;
                        {cs_d, sck_d, wr_d, rdb_d, de_d} = 5'h1f;
                        {soe_d, dboe_d} = 2'b00;
                        rv_d   = rd_q;
                        if (md_q != DHIP_MCU) begin
                            rsp_d = {{(DB_W-SER_W){1'b0}}, rx_d};
                        end
                    end else begin
                        st_d  = H_LOW;
                        sck_d = 1'b0;
                        soe_d = (bt_d < tb_q);
                        so_d  = sh_q[FRM_W-1];
                        if (md_q == DHIP_SER2) begin
                            wr_d = sh_q[FRM_W-2];                // R08
                            sh_d = {sh_q[FRM_W-3:0], 2'b00};
                        end else begin
                            sh_d = {sh_q[FRM_W-2:0], 1'b0};
                        end
                    end
                end
            end
            default: st_d = H_IDLE;
        endcase
    end

    // Sequencer and pin registers
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q <= H_IDLE;
            md_q <= DHIP_MCU;
            {tm_q, bt_q, nb_q, tb_q, sh_q, rx_q} <= '0;
            {rd_q, hs_q, vs_q} <= '0;
            {cs_q, sck_q, wr_q, rdb_q, pck_q, de_q} <= 6'h3e;
            {so_q, soe_q, dbo_q, dboe_q, rsp_q, rv_q} <= '0;
        end else begin
            st_q <= st_d;
            md_q <= md_d;
            {tm_q, bt_q, nb_q, tb_q, sh_q, rx_q} <= {tm_d, bt_d, nb_d, tb_d, sh_d, rx_d};
            {rd_q, hs_q, vs_q} <= {rd_d, hs_d, vs_d};
            {cs_q, sck_q, wr_q, rdb_q, pck_q, de_q} <= {cs_d, sck_d, wr_d, rdb_d, pck_d, de_d};
            {so_q, soe_q, dbo_q, dboe_q, rsp_q, rv_q} <= {so_d, soe_d, dbo_d, dboe_d, rsp_d, rv_d};
        end
    end

    // Pin and user outputs
    assign link.cs_b                   = cs_q;
    assign link.data_command_select    = sck_q;
    assign link.wr_b                   = wr_q;
    assign link.rd_b                   = rdb_q;
    assign link.interface_select_strap = i_strap;
    assign link.pclk                   = pck_q;
    assign link.pixel_data_enable      = de_q;
    assign link.hsync                  = hs_q;
    assign link.vsync                  = vs_q;
    assign link.h_sda_o                = so_q;
    assign link.h_sda_oe               = soe_q;
    assign link.h_db_o                 = dbo_q;
    assign link.h_db_oe                = dboe_q;
    assign o_rsp_valid                 = rv_q;
    assign o_rsp_data                  = rsp_q;
endmodule

// *** testbench/dhip_checker.sv ***
// Pin level checks between the host and display ends
`timescale 1ns/100ps
module dhip_checker
    import dhip_pkg::*;
(
    input wire logic            i_sys_clk,
    input wire logic            i_rst_b,
    input wire logic            i_cs_b,
    input wire logic            i_data_command_select,
    input wire logic            i_wr_b,
    input wire logic            i_rd_b,
    input wire logic            i_interface_select_strap,
    input wire logic            i_sda,
    input wire logic [DB_W-1:0] i_h_db_o,
    input wire logic            i_h_db_oe,
    input wire logic            i_d_db_oe,
    input wire logic            i_d_sda_oe
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    bus_one_drv_a: assert property (!(i_h_db_oe && i_d_db_oe)) else $error("bus clash");
    dev_drv_cause_a: assert property ($rose(i_d_db_oe) |-> !i_rd_b && !i_cs_b) else $error("bus unasked");
    dev_release_a: assert property ($rose(i_rd_b) |-> ##[1:8] !i_d_db_oe) else $error("bus kept");
    sda_strap_a: assert property (i_d_sda_oe |-> !i_interface_select_strap) else $error("sda driven");
    wr_width_a: assert property ($fell(i_wr_b) && i_h_db_oe |-> !i_wr_b [*8] ##1 i_wr_b) else $error("wr width");
    rd_width_a: assert property ($fell(i_rd_b) |-> (!i_rd_b && !i_cs_b) [*8] ##1 i_rd_b) else $error("rd width");
    wr_hold_a: assert property (!i_wr_b && i_h_db_oe |=> $stable(i_h_db_o)) else $error("data moved");
    ser_stable_a: assert property ($rose(i_data_command_select) && !i_cs_b |-> $stable(i_sda))
        else $error("sda moved");
endmodule

// *** testbench/tb.sv ***
// Bench joining the host end to the display end
`timescale 1ns/100ps
module tb;
    import dhip_pkg::*;
    logic            i_sys_clk, i_rst_b, rv, rrd, rdc, strap, ready, rspv, wv, wdc, pv, phs, pvs, pst;
    logic [DB_W-1:0] rdata, rdd, rspd, wd, pd;
    dhip_mode_t      mode;
    logic [2*DB_W:0] wq[$], rq[$], pq[$];  // Expected {mask, dc, word}
    int              bad_count = 0, samples_checked = 0, cyc = 0, seed = 32'hf906_fc69;
    dhip_if          lk();
    dhip_host u_dhip_host (.i_sys_clk, .i_rst_b, .link(lk.host), .i_mode(mode), .i_strap(strap), .i_req_valid(rv),
        .i_req_read(rrd), .i_req_dc(rdc), .i_req_data(rdata), .i_req_hsync(rdata[1]), .i_req_vsync(rdata[2]),
        .o_req_ready(ready), .o_rsp_valid(rspv), .o_rsp_data(rspd));
    dhip_dev u_dhip_dev (.i_sys_clk, .i_rst_b, .link(lk.dev), .i_mode(mode), .i_rd_data(rdd), .i_ser_rd_en(1'b1),
        .o_wr_valid(wv), .o_wr_is_data(wdc), .o_wr_data(wd), .o_pix_valid(pv), .o_pix_data(pd),
        .o_pix_hsync(phs), .o_pix_vsync(pvs), .o_strap(pst));
    dhip_checker u_dhip_checker (.i_sys_clk, .i_rst_b, .i_data_command_select(lk.data_command_select),
        .i_cs_b(lk.cs_b), .i_wr_b(lk.wr_b), .i_rd_b(lk.rd_b), .i_sda(lk.sda),
        .i_interface_select_strap(lk.interface_select_strap), .i_h_db_o(lk.h_db_o), .i_h_db_oe(lk.h_db_oe),
        .i_d_db_oe(lk.d_db_oe), .i_d_sda_oe(lk.d_sda_oe));
    // Masked compare of one result against the oldest note
    task automatic chk(input logic [2*DB_W:0] e, input logic [DB_W:0] g);
        samples_checked++;
        if ((g & {1'b1, e[2*DB_W:DB_W+1]}) !== e[DB_W:0]) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e[DB_W:0]);
        end
    endtask
    // Closing report
    task automatic summarize();
        if (wq.size() + rq.size() + pq.size() != 0) bad_count++;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One host request, expectations noted first
    task automatic xfer(input dhip_mode_t m, input logic rd, input logic st);
        logic [DB_W-1:0] k;
        k = (m == DHIP_MCU || m == DHIP_RGB) ? 18'h3_ffff : 18'h0_00ff;
        @(negedge i_sys_clk);
        mode = m;
        strap = st;
        repeat (4) @(negedge i_sys_clk);
        rdata = 18'($random(seed)) & k;
        rdd = 18'($random(seed));
        rrd = rd;
        rdc = rd ? 1'b0 : rdata[0];
        if (m == DHIP_RGB) begin
            pq.push_back({k, 1'b0, rdata});
            pq.push_back({18'h0_0007, 1'b0, 15'h0, st, rdata[2:1]});
        end else if (!rd || m != DHIP_MCU) wq.push_back({k, rdc, rdata});
        if (rd) rq.push_back({k, 1'b0, rdd & k});
        rv = 1'b1;
        @(posedge i_sys_clk);
        while (!ready) @(posedge i_sys_clk);
        @(negedge i_sys_clk) rv = 1'b0;
        repeat (2) @(posedge i_sys_clk);
        for (int i = 0; i < 600 && !ready; i++) @(posedge i_sys_clk);
        repeat (12) @(posedge i_sys_clk);
        $display("test mode %0d read %0d strap %0d done", m, rd, st);
    endtask
    // Result watcher
    always @(posedge i_sys_clk) begin
        if (wv) chk(wq.pop_front(), {wdc, wd});
        if (pv) chk(pq.pop_front(), {1'b0, pd});
        if (pv) chk(pq.pop_front(), {16'h0, pst, pvs, phs});
        if (rspv) chk(rq.pop_front(), {1'b0, rspd});
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        i_sys_clk = 1'b0;
        forever #2 i_sys_clk = ~i_sys_clk;
    end
    // Every mode written, all but RGB also read, strap low then high
    initial begin
        {i_rst_b, rv, rrd, rdc, strap, rdata, rdd} = '0;
        mode = DHIP_MCU;
        repeat (16) @(negedge i_sys_clk);
        i_rst_b = 1'b1;
        for (int r = 0; r < 2; r++) begin
            for (int m = 0; m < 5; m++) begin
                xfer(dhip_mode_t'(m), 1'b0, r[0]);
                if (m < 4) xfer(dhip_mode_t'(m), 1'b1, r[0]);
            end
        end
        summarize();
    end
endmodule
